// [hw/sfb_front_end.v]
// Operation
// - Sector n covers 4 KB from n*4 KB
// - Eight sectors form aligned 32 KB half block
// - Two half blocks form aligned 64 KB block
// - Works in clock modes 0 and 3
// - Inputs captured on serial clock rising edge
// - Outputs change only after serial clock falling
// - Dual read opcodes move data on two lanes
// - Lanes zero and one become bidirectional
// - Quad read opcodes move data on four
// - Lanes two and three replace protect, pause
// - Quad opcodes accepted only with enable bit
// - Unselected until first chip select falling edge
// - Ignore instructions while power-on reset held
// - Reset internal state when reset releases
// - Stop responding at once when reset returns
// - Chip select low means selected and active
// - Standby only once internal write cycle ends
// - Deselected ignores inputs, lanes high impedance
// - Enable bit is status_reg_two bit one
`timescale 1ns/1ps
`include "sfb_defs.vh"

// ==========================================
// Read-data FIFO
module sfb_fifo #(
	parameter W     = 8,
	parameter DEPTH = 8,
	parameter AW    = 3
) (
	input  wire         sys_clk_i,
	input  wire         nrst_i,
	input  wire [W-1:0] in_data_i,
	input  wire         in_valid_i,
	output wire         in_ready_o,
	output wire [W-1:0] out_data_o,
	output wire         out_valid_o,
	input  wire         out_ready_i
);
	reg  [W-1:0] mem [0:DEPTH-1];
	reg  [AW:0]  wr_q;
	reg  [AW:0]  rd_q;
	wire         full  = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
	wire         empty = (wr_q == rd_q);

	assign in_ready_o  = ~full;
	assign out_valid_o = ~empty;
	assign out_data_o  = mem[rd_q[AW-1:0]];

	always @(posedge sys_clk_i)
	begin
		if (in_valid_i && !full)
			mem[wr_q[AW-1:0]] <= in_data_i;
	end

	always @(posedge sys_clk_i)
	begin
		if (!nrst_i)
		begin
			wr_q <= {(AW+1){1'b0}};
			rd_q <= {(AW+1){1'b0}};
		end
		else
		begin
			if (in_valid_i && !full)
				wr_q <= wr_q + 1'b1;
			if (out_ready_i && !empty)
				rd_q <= rd_q + 1'b1;
		end
	end
endmodule

// ==========================================
// Serial bus front end
module sfb_front_end #(
	parameter FIFO_DEPTH = 8,
	parameter FIFO_AW    = 3
) (
	input  wire        sys_clk_i,
	input  wire        nrst_i,
	input  wire        sclk_i,
	input  wire        cs_n_i,
	input  wire [3:0]  lane_i,
	output reg  [3:0]  lane_o,
	output wire [3:0]  lane_oe_o,
	input  wire [7:0]  status_reg_two_i,
	input  wire        busy_i,
	output wire        selected_o,
	output wire        standby_o,
	output wire        wp_n_o,
	output wire        hold_n_o,
	output reg  [7:0]  opcode_o,
	output reg         opcode_valid_o,
	output reg  [23:0] addr_o,
	output reg         addr_valid_o,
	output reg  [8:0]  sector_o,
	output reg  [5:0]  half_block_o,
	output reg  [4:0]  block_o,
	output reg  [7:0]  rx_byte_o,
	output reg         rx_valid_o,
	input  wire [7:0]  rd_data_i,
	input  wire        rd_valid_i,
	output wire        rd_ready_o
);
	localparam ST_IDLE   = 3'h0;
	localparam ST_CMD    = 3'h1;
	localparam ST_ADDR   = 3'h2;
	localparam ST_DUMMY  = 3'h3;
	localparam ST_DOUT   = 3'h4;
	localparam ST_DIN    = 3'h5;
	localparam ST_IGNORE = 3'h6;

	// ==========================================
	// Pin synchronisers
	reg [1:0] sclk_sq;
	reg       sclk_p_q;
	reg [1:0] cs_sq;
	reg       cs_p_q;
	reg [3:0] lane_s1_q;
	reg [3:0] lane_s2_q;

	always @(posedge sys_clk_i)
	begin
		if (!nrst_i)
		begin
			sclk_sq   <= 2'h0;
			sclk_p_q  <= 1'b0;
			cs_sq     <= 2'h0;
			cs_p_q    <= 1'b0;
			lane_s1_q <= 4'hf;
			lane_s2_q <= 4'hf;
		end
		else
		begin
			sclk_sq   <= {sclk_sq[0], sclk_i};
			sclk_p_q  <= sclk_sq[1];
			cs_sq     <= {cs_sq[0], cs_n_i};
			cs_p_q    <= cs_sq[1];
			lane_s1_q <= lane_i;
			lane_s2_q <= lane_s1_q;
		end
	end

	wire sclk_rise = sclk_sq[1] & ~sclk_p_q;
	wire sclk_fall = ~sclk_sq[1] & sclk_p_q;
	// Previous level resets low, so a chip select held low through reset never counts as an edge
	wire cs_fall   = ~cs_sq[1] & cs_p_q;

	// ==========================================
	// Selection and power state
	reg  armed_q;
	wire qe  = status_reg_two_i[`SFB_QE_BIT];
	// The arming edge selects at once, so the first frame after reset is not lost
	wire sel = (armed_q | cs_fall) & ~cs_sq[1];

	always @(posedge sys_clk_i)
	begin
		if (!nrst_i)
			armed_q <= 1'b0;
		else if (cs_fall)
			armed_q <= 1'b1;
	end

	assign selected_o = sel;
	assign standby_o  = ~sel & ~busy_i;
	assign wp_n_o     = qe ? 1'b1 : lane_s2_q[2];
	assign hold_n_o   = qe ? 1'b1 : lane_s2_q[3];

	// ==========================================
	// Receive shifter
	reg [2:0]  state_q;
	reg [23:0] sh_q;
	reg [5:0]  cnt_q;
	reg [2:0]  w_q;
	reg [2:0]  w_data_q;
	reg [3:0]  dummy_q;

	// Highest lane carries the most significant bit of each group
	function [23:0] shift_in;
		input [23:0] s;
		input [2:0]  w;
		input [3:0]  l;
		begin
			case (w)
				`SFB_W2: shift_in = {s[21:0], l[1:0]};
				`SFB_W4: shift_in = {s[19:0], l};
				default: shift_in = {s[22:0], l[0]};
			endcase
		end
	endfunction

	wire [23:0] sh_nx  = shift_in(sh_q, w_q, lane_s2_q);
	wire [5:0]  cnt_nx = cnt_q + {3'h0, w_q};
	wire [7:0]  op_nx  = sh_nx[7:0];

	always @(posedge sys_clk_i)
	begin
		if (!nrst_i)
		begin
			state_q        <= ST_IDLE;
			sh_q           <= 24'h0;
			cnt_q          <= 6'h0;
			w_q            <= `SFB_W1;
			w_data_q       <= `SFB_W1;
			dummy_q        <= `SFB_DUMMY_NONE;
			opcode_o       <= 8'h0;
			opcode_valid_o <= 1'b0;
			addr_o         <= 24'h0;
			addr_valid_o   <= 1'b0;
			sector_o       <= 9'h0;
			half_block_o   <= 6'h0;
			block_o        <= 5'h0;
			rx_byte_o      <= 8'h0;
			rx_valid_o     <= 1'b0;
		end
		else
		begin
			opcode_valid_o <= 1'b0;
			addr_valid_o   <= 1'b0;
			rx_valid_o     <= 1'b0;
			if (!sel)
				state_q <= ST_IDLE;
			else if (cs_fall)
			begin
				state_q <= ST_CMD;
				cnt_q   <= 6'h0;
				w_q     <= `SFB_W1;
			end
			else if (sclk_rise)
			begin
				sh_q  <= sh_nx;
				cnt_q <= cnt_nx;
				case (state_q)
					ST_CMD:
					begin
						if (cnt_q == `SFB_CMD_LAST)
						begin
							opcode_o       <= op_nx;
							opcode_valid_o <= 1'b1;
							cnt_q          <= 6'h0;
							state_q        <= ST_ADDR;
							case (op_nx)
								`SFB_OP_READ:
								begin
									w_data_q <= `SFB_W1;
									dummy_q  <= `SFB_DUMMY_NONE;
								end
								`SFB_OP_FAST:
								begin
									w_data_q <= `SFB_W1;
									dummy_q  <= `SFB_DUMMY_FAST;
								end
								`SFB_OP_DUAL_OUT:
								begin
									w_data_q <= `SFB_W2;
									dummy_q  <= `SFB_DUMMY_FAST;
								end
								`SFB_OP_DUAL_IO:
								begin
									w_q      <= `SFB_W2;
									w_data_q <= `SFB_W2;
									dummy_q  <= `SFB_DUMMY_DUALIO;
								end
								`SFB_OP_QUAD_OUT:
								begin
									w_data_q <= `SFB_W4;
									dummy_q  <= `SFB_DUMMY_FAST;
									if (!qe)
										state_q <= ST_IGNORE;
								end
								`SFB_OP_QUAD_IO:
								begin
									w_q      <= `SFB_W4;
									w_data_q <= `SFB_W4;
									dummy_q  <= `SFB_DUMMY_QUADIO;
									if (!qe)
										state_q <= ST_IGNORE;
								end
								default:
									state_q <= ST_DIN;
							endcase
						end
					end
					ST_ADDR:
					begin
						if (cnt_nx == `SFB_ADDR_BITS)
						begin
							addr_o       <= sh_nx;
							addr_valid_o <= 1'b1;
							sector_o     <= sh_nx[`SFB_SECTOR_MSB:`SFB_SECTOR_LSB];
							half_block_o <= sh_nx[`SFB_SECTOR_MSB:`SFB_HALF_LSB];
							block_o      <= sh_nx[`SFB_SECTOR_MSB:`SFB_BLOCK_LSB];
							cnt_q        <= 6'h0;
							if (dummy_q == `SFB_DUMMY_NONE)
							begin
								state_q <= ST_DOUT;
								w_q     <= w_data_q;
							end
							else
								state_q <= ST_DUMMY;
						end
					end
					ST_DUMMY:
					begin
						dummy_q <= dummy_q - 4'h1;
						if (dummy_q == 4'h1)
						begin
							state_q <= ST_DOUT;
							w_q     <= w_data_q;
						end
					end
					ST_DIN:
					begin
						if (cnt_nx == {2'h0, `SFB_BYTE_BITS})
						begin
							rx_byte_o  <= sh_nx[7:0];
							rx_valid_o <= 1'b1;
							cnt_q      <= 6'h0;
						end
					end
					default:
						cnt_q <= 6'h0;
				endcase
			end
		end
	end

	// ==========================================
	// Transmit shifter, driven only after falling edges
	wire [7:0] fifo_data;
	wire       fifo_valid;
	reg  [7:0] tx_q;
	reg  [3:0] left_q;
	reg        drive_q;
	wire       in_dout = sel & (state_q == ST_DOUT);
	wire       need    = in_dout & sclk_fall & (left_q == 4'h0);
	wire [7:0] tx_byte = fifo_valid ? fifo_data : `SFB_FILL_BYTE;
	wire [7:0] tx_src  = (left_q == 4'h0) ? tx_byte : tx_q;
	wire [3:0] step    = {1'b0, w_q};

	// Stalls the user's source once the FIFO holds a full burst
	sfb_fifo #(
		.W     (8),
		.DEPTH (FIFO_DEPTH),
		.AW    (FIFO_AW)
	) u_fifo (
		.sys_clk_i   (sys_clk_i),
		.nrst_i      (nrst_i),
		.in_data_i   (rd_data_i),
		.in_valid_i  (rd_valid_i),
		.in_ready_o  (rd_ready_o),
		.out_data_o  (fifo_data),
		.out_valid_o (fifo_valid),
		.out_ready_i (need)
	);

	always @(posedge sys_clk_i)
	begin
		if (!nrst_i)
		begin
			tx_q    <= 8'h0;
			left_q  <= 4'h0;
			drive_q <= 1'b0;
			lane_o  <= 4'h0;
		end
		else if (!in_dout)
		begin
			left_q  <= 4'h0;
			drive_q <= 1'b0;
		end
		else if (sclk_fall)
		begin
			drive_q <= 1'b1;
			case (w_q)
				`SFB_W2: lane_o <= {2'h0, tx_src[7:6]};
				`SFB_W4: lane_o <= tx_src[7:4];
				default: lane_o <= {2'h0, tx_src[7], 1'b0};
			endcase
			tx_q   <= tx_src << w_q;
			left_q <= (left_q == 4'h0) ? (`SFB_BYTE_BITS - step) : (left_q - step);
		end
	end

	// Only the lanes in use are driven; the rest stay released for the host
	assign lane_oe_o = !(drive_q && in_dout) ? 4'h0 :
	                   (w_q == `SFB_W4) ? 4'hf :
	                   (w_q == `SFB_W2) ? 4'h3 : 4'h2;
endmodule

// [hw/sfb_defs.vh]
`ifndef SFB_DEFS_VH
`define SFB_DEFS_VH
// ==========================================
// Read opcodes that move data out
`define SFB_OP_READ      8'h03
`define SFB_OP_FAST      8'h0b
`define SFB_OP_DUAL_OUT  8'h3b
`define SFB_OP_DUAL_IO   8'hbb
`define SFB_OP_QUAD_OUT  8'h6b
`define SFB_OP_QUAD_IO   8'heb
// ==========================================
// Frame field lengths in bits (command given as its last bit index)
`define SFB_CMD_LAST     6'h07
`define SFB_ADDR_BITS    6'h18
`define SFB_BYTE_BITS    4'h8
// ==========================================
// Dummy clocks between address and data (mode bits folded in)
`define SFB_DUMMY_NONE   4'h0
`define SFB_DUMMY_FAST   4'h8
`define SFB_DUMMY_DUALIO 4'h4
`define SFB_DUMMY_QUADIO 4'h6
// ==========================================
// Lane widths
`define SFB_W1           3'h1
`define SFB_W2           3'h2
`define SFB_W4           3'h4
// ==========================================
// Status register two and address map fields
`define SFB_QE_BIT       1
`define SFB_SECTOR_MSB   20
`define SFB_SECTOR_LSB   12
`define SFB_HALF_LSB     15
`define SFB_BLOCK_LSB    16
// Byte sent when the read-data FIFO has run dry
`define SFB_FILL_BYTE    8'hff
`endif

// [sim/sfb_front_end_chk.sv]
`timescale 1ns/1ps
// ==========================================
// Port checks of the serial front end
module sfb_front_end_chk (
	input wire        sys_clk_i,
	input wire        nrst_i,
	input wire        sclk_i,
	input wire        cs_n_i,
	input wire [7:0]  status_reg_two_i,
	input wire        busy_i,
	input wire [3:0]  lane_o,
	input wire [3:0]  lane_oe_o,
	input wire        selected_o,
	input wire        standby_o,
	input wire        wp_n_o,
	input wire        hold_n_o,
	input wire        opcode_valid_o,
	input wire [23:0] addr_o,
	input wire        addr_valid_o,
	input wire [8:0]  sector_o,
	input wire [5:0]  half_block_o,
	input wire [4:0]  block_o
);
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!nrst_i);

	a_idle_undriven: assert property (cs_n_i[*5] |-> lane_oe_o == 4'h0)
		else $error("lanes driven while deselected");
	a_desel_quiet: assert property (cs_n_i[*4] |-> !selected_o)
		else $error("selected while chip select high");
	a_standby_level: assert property (standby_o == (!selected_o && !busy_i))
		else $error("standby level wrong");
	a_quad_pins: assert property (status_reg_two_i[1][*2] |-> wp_n_o && hold_n_o)
		else $error("protect or pause active in quad mode");
	a_quad_gate: assert property (!status_reg_two_i[1] |-> lane_oe_o[3:2] == 2'b00)
		else $error("upper lanes driven without quad enable");
	a_lane_fall: assert property ($changed(lane_o) && (|lane_oe_o) |-> !$past(sclk_i, 2))
		else $error("lane changed away from falling edge");
	a_capture_rise: assert property (opcode_valid_o |-> $past(sclk_i, 2))
		else $error("opcode taken away from rising edge");
	a_addr_map: assert property (addr_valid_o |-> sector_o == addr_o[20:12]
		&& half_block_o == addr_o[20:15] && block_o == addr_o[20:16])
		else $error("address map wrong");
endmodule

// [sim/sfb_host.sv]
`timescale 1ns/1ps
// ==========================================
// Host controller model, clock mode 0 or 3
module sfb_host (
	input  wire [3:0] lane_i,
	output reg        sclk_o,
	output reg        cs_n_o,
	output reg  [3:0] lane_o,
	output reg  [3:0] lane_oe_o
);
	reg     cpol;
	integer slow;

	initial
	begin
		cpol = 1'b0;
		slow = 0;
		sclk_o = 1'b0;
		cs_n_o = 1'b1;
		lane_o = 4'h0;
		lane_oe_o = 4'h0;
	end

	task tick(input [3:0] v, input [3:0] oe);
	begin
		sclk_o = 1'b0;
		// Released lanes toggle so stale data never looks valid
		lane_o = (oe & v) | (~oe & ~lane_o);
		lane_oe_o = oe;
		#(100 + slow);
		sclk_o = 1'b1;
		#100;
	end
	endtask

	// Read data is taken late in the high phase to cover the device's sync delay
	task frame(input [7:0] op, input [23:0] a, input integer na, input [2:0] aw,
		input [3:0] dum, input [2:0] dw, input integer nb, output [63:0] rd);
		integer    i;
		reg [23:0] s;
		reg [3:0]  m;
	begin
		rd = 64'h0;
		sclk_o = cpol;
		#100;
		cs_n_o = 1'b0;
		for (i = 7; i >= 0; i = i - 1)
			tick({3'h0, op[i]}, 4'h1);
		m = (4'h1 << aw) - 4'h1;
		for (i = na - aw; i >= 0; i = i - aw)
		begin
			s = a >> i;
			tick(s[3:0] & m, m);
		end
		repeat (dum)
			tick(4'h0, 4'h0);
		m = (4'h1 << dw) - 4'h1;
		for (i = 0; i < nb * 8; i = i + dw)
		begin
			tick(4'h0, 4'h0);
			rd = (rd << dw) | (dw == 3'h1 ? {63'h0, lane_i[1]} : {60'h0, lane_i & m});
		end
		sclk_o = cpol;
		#100;
		cs_n_o = 1'b1;
	end
	endtask
endmodule

// [sim/sfb_front_end_bench.sv]
`timescale 1ns/1ps
`include "sfb_defs.vh"
// ==========================================
// Bench: host model on the pins, tasks feed the read FIFO
module sfb_front_end_bench;
	reg         clk;
	reg         nrst;
	reg         busy;
	reg  [7:0]  sr2;
	reg  [7:0]  rd_data;
	reg         rd_valid;
	wire [3:0]  d_lane, d_oe, h_lane, h_oe, pin;
	wire        sclk, cs_n, rd_ready, sel, stby, ov, av, rv;
	wire [23:0] addr;
	wire [7:0]  rx, opc;
	reg  [23:0] cap_a;
	reg  [7:0]  cap_rx;
	reg  [7:0]  cap_op;
	reg         cap_sel;
	reg  [63:0] r;
	integer     n_addr, mismatches, checked, m;

	// Lanes two and three have pull-ups
	assign pin = (d_oe & d_lane) | (~d_oe & h_oe & h_lane) | (~d_oe & ~h_oe & {2'b11, h_lane[1:0]});

	initial
	begin
		clk = 1'b0;
		forever
			#12.5 clk = ~clk;
	end

	sfb_front_end dut (.sys_clk_i(clk), .nrst_i(nrst), .sclk_i(sclk), .cs_n_i(cs_n), .lane_i(pin),
		.lane_o(d_lane), .lane_oe_o(d_oe), .status_reg_two_i(sr2), .busy_i(busy), .selected_o(sel),
		.standby_o(stby), .wp_n_o(), .hold_n_o(), .opcode_o(opc), .opcode_valid_o(ov), .addr_o(addr),
		.addr_valid_o(av), .sector_o(), .half_block_o(), .block_o(), .rx_byte_o(rx), .rx_valid_o(rv),
		.rd_data_i(rd_data), .rd_valid_i(rd_valid), .rd_ready_o(rd_ready));
	sfb_host host (.lane_i(pin), .sclk_o(sclk), .cs_n_o(cs_n), .lane_o(h_lane), .lane_oe_o(h_oe));

	always @(posedge clk)
	begin
		n_addr <= n_addr + av;
		cap_a <= av ? addr : cap_a;
		cap_rx <= rv ? rx : cap_rx;
		cap_op <= ov ? opc : cap_op;
		cap_sel <= ov ? sel : cap_sel;
	end

	task chk(input [63:0] got, input [63:0] exp);
	begin
		checked = checked + 1;
		if (got !== exp)
		begin
			mismatches = mismatches + 1;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	end
	endtask

	task end_sim;
	begin
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	end
	endtask

	task push(input [7:0] b);
	begin
		while (rd_ready !== 1'b1)
		begin
			@(posedge clk);
			#1;
		end
		rd_data = b;
		rd_valid = 1'b1;
		@(posedge clk);
		#1 rd_valid = 1'b0;
		@(posedge clk);
		#1;
	end
	endtask

	task t_power;
	begin
		nrst = 1'b0;
		busy = 1'b1;
		sr2 = 8'h00;
		#1 host.cs_n_o = 1'b0;
		repeat (10) @(posedge clk);
		#1 chk(d_oe, 4'h0);
		nrst = 1'b1;
		repeat (20) @(posedge clk);
		#1 chk(sel, 1'b0);
		host.cs_n_o = 1'b1;
		repeat (8) @(posedge clk);
		#1 chk(stby, 1'b0);
		busy = 1'b0;
		#25 chk(stby, 1'b1);
	end
	endtask

	task rd_test(input [7:0] op, input [2:0] aw, input [3:0] dum, input [2:0] dw);
		reg [23:0] a;
	begin
		a = {3'h0, host.cpol, op, 12'hffe};
		push(op);
		push(~op);
		host.frame(op, a, 24, aw, dum, dw, 2, r);
		chk(r[15:0], {op, ~op});
		chk(cap_a, a);
		chk(cap_op, op);
		chk(cap_sel, 1'b1);
	end
	endtask

	task t_refuse;
		integer k;
	begin
		#200 sr2 = 8'h00;
		k = n_addr;
		host.frame(`SFB_OP_QUAD_IO, 24'h012345, 24, 3'h4, `SFB_DUMMY_QUADIO, 3'h4, 1, r);
		chk(n_addr, k);
		host.frame(8'h02, 24'h0000a5, 8, 3'h1, 4'h0, 3'h1, 0, r);
		chk(cap_rx, 8'ha5);
		chk(cap_op, 8'h02);
	end
	endtask

	task t_fifo;
		integer k;
	begin
		for (k = 0; k < 8; k = k + 1)
			push(8'h10 + k[7:0]);
		chk(rd_ready, 1'b0);
		host.slow = 150;
		host.frame(`SFB_OP_READ, 24'h1ff000, 24, 3'h1, 4'h0, 3'h1, 8, r);
		chk(r, 64'h1011121314151617);
		host.slow = 0;
		host.frame(`SFB_OP_READ, 24'h000fff, 24, 3'h1, 4'h0, 3'h1, 1, r);
		chk(r, {56'h0, `SFB_FILL_BYTE});
	end
	endtask

	task t_mid;
	begin
		push(8'h3c);
		fork
			host.frame(`SFB_OP_READ, 24'h0, 24, 3'h1, 4'h0, 3'h1, 2, r);
			begin
				#8000 nrst = 1'b0;
				repeat (4) @(posedge clk);
				#1 chk(d_oe, 4'h0);
				nrst = 1'b1;
				repeat (6) @(posedge clk);
				#1 chk(sel, 1'b0);
			end
		join
		rd_test(`SFB_OP_DUAL_OUT, 3'h1, `SFB_DUMMY_FAST, 3'h2);
	end
	endtask

	initial
	begin
		mismatches = 0;
		checked = 0;
		n_addr = 0;
		rd_data = 8'h00;
		rd_valid = 1'b0;
		t_power;
		for (m = 0; m < 2; m = m + 1)
		begin
			host.cpol = m[0];
			sr2 = 8'h02;
			rd_test(`SFB_OP_READ, 3'h1, `SFB_DUMMY_NONE, 3'h1);
			rd_test(`SFB_OP_FAST, 3'h1, `SFB_DUMMY_FAST, 3'h1);
			rd_test(`SFB_OP_DUAL_OUT, 3'h1, `SFB_DUMMY_FAST, 3'h2);
			rd_test(`SFB_OP_DUAL_IO, 3'h2, `SFB_DUMMY_DUALIO, 3'h2);
			rd_test(`SFB_OP_QUAD_OUT, 3'h1, `SFB_DUMMY_FAST, 3'h4);
			rd_test(`SFB_OP_QUAD_IO, 3'h4, `SFB_DUMMY_QUADIO, 3'h4);
		end
		t_refuse;
		t_fifo;
		t_mid;
		end_sim;
	end

	// Run is near 175 us; the limit leaves ample margin
	initial
	begin
		#1000000;
		mismatches = mismatches + 1;
		end_sim;
	end
endmodule

bind sfb_front_end sfb_front_end_chk chk (.*);
